// File: core/bts_consts.vh
/*
 * constants for the bit test / soft trap execution block: opcodes, field
 * positions, vector table base, stack steps, status bit positions.
 * assumes it is included by bare name from core/ sources.
 */
`ifndef BTS_CONSTS_VH
`define BTS_CONSTS_VH

// opcode words
`define BTS_OP_CLR_W1 16'h5609
`define BTS_OP_SET_W1 16'h560d
`define BTS_OP_SUM_TEST 16'hff58
`define BTS_OP_TRAP_MASK 16'hffe0
`define BTS_OP_TRAP_VAL 16'h0020
`define BTS_OP_W2_ZERO_MASK 16'hf000

// field positions: bit and mode in the second word, vector in the first word
`define BTS_BIT_HI 11
`define BTS_BIT_LO 8
`define BTS_MODE_HI 7
`define BTS_MODE_LO 0
`define BTS_VEC_HI 4
`define BTS_VEC_LO 0

// special addressing mode codes meaning low / high accumulator half
`define BTS_MODE_SUM_LO 8'ha9
`define BTS_MODE_SUM_HI 8'ha8

// sign bit positions
`define BTS_SIGN16 15
`define BTS_SIGN32 31

// status word b bit positions
`define BTS_STB_IRQ_MASK 0
`define BTS_STB_DBG_MASK 1
`define BTS_STB_LOOP 4
`define BTS_STB_PERMIT 6
`define BTS_STB_SLEEP 7

// context save
`define BTS_STK_FIRST_STEP 16'h0001
`define BTS_STK_STEP 16'h0002
`define BTS_SAVE_LAST 3'h6
`define BTS_RET_STEP 22'h000001

// vector table base in data space, two words per vector
`define BTS_VEC_BASE 22'h000d00

`endif

// File: core/bts_exec.v
/*
 * execution logic for the bit test-and-clear / test-and-set group, the
 * accumulator zero test and the software trap.
 * assumes: one core clock, a single-cycle memory port with read data valid
 * the cycle after a read strobe, and an outer pipeline that obeys busy.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bts_consts.vh"

// Behaviour
// - test-and-clear: read, copy bit, write bit zero
// - decode test-and-clear two-word form
// - bit index selects bit directly, 0 is lsb
// - accumulator half target sets sign, zero flags
// - probe flag takes old tested bit value
// - test-and-set: read, copy bit, write bit one
// - decode test-and-set two-word form
// - after repeat prefix clear counter, run once
// - accumulator test: sign is bit 31, zero
// - accumulator test fixed opcode, accumulator unchanged
// - trap low five bits pick one vector
// - trap ignores masks, pending, enable registers
// - no hardware interrupt from decode to handler
// - vector numbers map to fixed event kinds
// - pairs saved as 32-bit writes, low even
// - stack bump one, push pairs, step two
// - after save set masks, clear mode flags
// - vector zero only jumps, no core reset
module bts_exec #(
	parameter DW = 16, // data word width
	parameter AW = 22 // address width
) (
	input wire core_clk, // core clock, 40 MHz
	input wire sys_rst, // synchronous reset, active high
	input wire instr_valid, // decode stage holds a word
	input wire [DW-1:0] instr_word1, // first opcode word
	input wire [DW-1:0] instr_word2, // second opcode word
	input wire [AW-1:0] instr_pc, // address of first word
	input wire repeat_active, // previous instruction was repeat prefix
	input wire [AW-1:0] operand_addr, // resolved operand address
	input wire [2*DW-1:0] sum_register, // accumulator
	input wire [DW-1:0] status_word_a, // status word a
	input wire [DW-1:0] status_word_b, // status word b
	input wire [DW-1:0] mul_high, // multiplicand high
	input wire [2*DW-1:0] product, // product register
	input wire [2*DW-1:0] aux_pair, // aux1:aux0
	input wire [DW-1:0] page_pointer, // page pointer
	input wire [DW-1:0] debug_status_reg, // debug status
	input wire [DW-1:0] irq_enable_reg, // interrupt enable
	input wire [DW-1:0] stack_pointer, // stack pointer
	input wire [2*DW-1:0] mem_rdata, // memory read data
	output reg busy, // instruction in progress, stall decode
	output reg bit_probe_flag, // probe flag
	output reg flag_n, // sign flag
	output reg flag_z, // zero flag
	output reg flags_we, // pulse: sign/zero updated
	output reg sum_half_we, // pulse: write accumulator half
	output reg sum_half_sel, // 1 high half, 0 low half
	output reg [DW-1:0] sum_half_wdata, // new half value
	output reg repeat_counter_clr, // pulse: clear repeat counter
	output reg irq_block, // hold off hardware interrupts
	output reg pipe_flush, // pulse: flush fetch stages
	output reg mem_rd, // pulse: read strobe
	output reg mem_wr, // pulse: write strobe
	output reg mem_wide, // 32-bit access
	output reg [AW-1:0] mem_addr, // memory address
	output reg [2*DW-1:0] mem_wdata, // write data, low word in low bits
	output reg [DW-1:0] stack_pointer_new, // new stack pointer
	output reg stack_pointer_we, // pulse: load stack pointer
	output reg [DW-1:0] status_word_b_new, // new status word b
	output reg status_word_b_we, // pulse: load status word b
	output reg pc_load, // pulse: load program counter
	output reg [AW-1:0] pc_value, // program counter target
	output reg [3:0] vector_kind // class of the taken vector
);

////////////////////////////////////////////////////////////////////////////
// states and vector classes
localparam ST_IDLE = 3'h0; // waiting for an instruction
localparam ST_RMW_RD = 3'h1; // operand read issued
localparam ST_RMW_WR = 3'h2; // modify and write back
localparam ST_TRAP_VEC = 3'h3; // fetched vector latched
localparam ST_TRAP_SAVE = 3'h4; // pushing register pairs
localparam ST_TRAP_END = 3'h5; // mode bits and jump
localparam ST_TRAP_GAP = 3'h6; // vector read in flight

localparam K_RESET = 4'h0; // reset handler
localparam K_MASKABLE = 4'h1; // maskable line
localparam K_DLOG = 4'h2; // data logging
localparam K_RTOS = 4'h3; // realtime os
localparam K_RESERVED = 4'h4; // reserved slot
localparam K_NMI = 4'h5; // non-maskable
localparam K_ILLEGAL = 4'h6; // illegal instruction
localparam K_USER = 4'h7; // user trap

////////////////////////////////////////////////////////////////////////////
// helpers

// class of vector number
// the class is only reported; the handler address always comes from
// the table, so a wrong class never changes where the trap lands
function [3:0] vec_class;
	input [4:0] v;
	begin
		if (v == 5'h00) vec_class = K_RESET;
		else if (v <= 5'h0e) vec_class = K_MASKABLE;
		else if (v == 5'h0f) vec_class = K_DLOG;
		else if (v == 5'h10) vec_class = K_RTOS;
		else if (v == 5'h11) vec_class = K_RESERVED;
		else if (v == 5'h12) vec_class = K_NMI;
		else if (v == 5'h13) vec_class = K_ILLEGAL;
		else vec_class = K_USER;
	end
endfunction

// one-hot mask from a four-bit index, index 0 is lsb
function [15:0] bit_mask;
	input [3:0] idx;
	begin
		bit_mask = 16'h0001 << idx;
	end
endfunction

////////////////////////////////////////////////////////////////////////////
// decode
// only exact first words, or the trap pattern with any vector, are taken; anything else passes untouched so
// the outer decoder keeps ownership of the rest of the set
wire w2_ok = (instr_word2 & `BTS_OP_W2_ZERO_MASK) == 16'h0000; // upper nibble zero
wire dec_bit_clr = instr_valid && instr_word1 == `BTS_OP_CLR_W1 && w2_ok;
wire dec_bit_set = instr_valid && instr_word1 == `BTS_OP_SET_W1 && w2_ok;
wire dec_test = instr_valid && instr_word1 == `BTS_OP_SUM_TEST;
wire dec_trap = instr_valid && (instr_word1 & `BTS_OP_TRAP_MASK) == `BTS_OP_TRAP_VAL;
wire [3:0] dec_bit = instr_word2[`BTS_BIT_HI:`BTS_BIT_LO];
wire [7:0] dec_mode = instr_word2[`BTS_MODE_HI:`BTS_MODE_LO];
wire dec_is_half = dec_mode == `BTS_MODE_SUM_LO || dec_mode == `BTS_MODE_SUM_HI;

////////////////////////////////////////////////////////////////////////////
// working registers
// bit index, target and address are latched at the take edge, so the decode stage may move
// on while the sequencer is still busy; the accumulator and the saved registers are read live
reg [2:0] state_reg; // sequencer state
reg set_mode_reg; // 1 test-and-set, 0 test-and-clear
reg [3:0] bit_reg; // latched bit index
reg half_reg; // target is accumulator half
reg half_hi_reg; // which half
reg [AW-1:0] addr_reg; // operand address
reg [4:0] vec_reg; // trap vector number
reg [AW-1:0] ret_reg; // return address
reg [AW-1:0] vec_target_reg; // fetched vector
reg [2:0] save_idx_reg; // pair being pushed
reg [DW-1:0] sp_reg; // running stack pointer

// modified operand; bit_reg picks the bit
wire [15:0] cur_mask = bit_mask(bit_reg);
// tested word: the selected accumulator half for a register target,
// otherwise the word the memory returned
wire [15:0] half_word = half_hi_reg ? sum_register[2*DW-1:DW] : sum_register[DW-1:0];
wire [15:0] old_word = half_reg ? half_word : mem_rdata[DW-1:0];
wire [15:0] new_word = set_mode_reg ? (old_word | cur_mask) : (old_word & ~cur_mask);

// pair to push for each save step, low register in low bits
reg [2*DW-1:0] save_pair;
always @* begin
	case (save_idx_reg)
	3'h0: save_pair = {mul_high, status_word_a};
	3'h1: save_pair = sum_register;
	3'h2: save_pair = product;
	3'h3: save_pair = aux_pair;
	3'h4: save_pair = {page_pointer, status_word_b};
	3'h5: save_pair = {debug_status_reg, irq_enable_reg};
	3'h6: save_pair = {{(2*DW-AW){1'b0}}, ret_reg};
	default: save_pair = {2*DW{1'b0}};
	endcase
end

////////////////////////////////////////////////////////////////////////////
// sequencer; every output is a register
// one machine runs the whole group; the trap walks gap, vector latch,
// seven pushes and the mode update, and interrupts stay held
// for that whole length
always @(posedge core_clk) begin
	if (sys_rst) begin
		state_reg <= ST_IDLE;
		set_mode_reg <= 1'b0;
		bit_reg <= 4'h0;
		half_reg <= 1'b0;
		half_hi_reg <= 1'b0;
		addr_reg <= {AW{1'b0}};
		vec_reg <= 5'h00;
		ret_reg <= {AW{1'b0}};
		vec_target_reg <= {AW{1'b0}};
		save_idx_reg <= 3'h0;
		sp_reg <= {DW{1'b0}};
		busy <= 1'b0;
		bit_probe_flag <= 1'b0;
		flag_n <= 1'b0;
		flag_z <= 1'b0;
		flags_we <= 1'b0;
		sum_half_we <= 1'b0;
		sum_half_sel <= 1'b0;
		sum_half_wdata <= {DW{1'b0}};
		repeat_counter_clr <= 1'b0;
		irq_block <= 1'b0;
		pipe_flush <= 1'b0;
		mem_rd <= 1'b0;
		mem_wr <= 1'b0;
		mem_wide <= 1'b0;
		mem_addr <= {AW{1'b0}};
		mem_wdata <= {2*DW{1'b0}};
		stack_pointer_new <= {DW{1'b0}};
		stack_pointer_we <= 1'b0;
		status_word_b_new <= {DW{1'b0}};
		status_word_b_we <= 1'b0;
		pc_load <= 1'b0;
		pc_value <= {AW{1'b0}};
		vector_kind <= 4'h0;
	end else begin
		// pulses default low
		flags_we <= 1'b0;
		sum_half_we <= 1'b0;
		repeat_counter_clr <= 1'b0;
		pipe_flush <= 1'b0;
		mem_rd <= 1'b0;
		mem_wr <= 1'b0;
		stack_pointer_we <= 1'b0;
		status_word_b_we <= 1'b0;
		pc_load <= 1'b0;
		case (state_reg)
		ST_IDLE: begin
			// none of these repeat: a pending repeat is cancelled
			if ((dec_bit_clr || dec_bit_set || dec_test || dec_trap) && repeat_active)
				repeat_counter_clr <= 1'b1;
			if (dec_bit_clr || dec_bit_set) begin
				set_mode_reg <= dec_bit_set;
				bit_reg <= dec_bit;
				half_reg <= dec_is_half;
				half_hi_reg <= dec_mode == `BTS_MODE_SUM_HI;
				addr_reg <= operand_addr;
				// a register half needs no bus cycle; the word is
				// taken from the accumulator input instead
				mem_rd <= !dec_is_half;
				mem_wide <= 1'b0;
				mem_addr <= operand_addr;
				busy <= 1'b1;
				state_reg <= ST_RMW_RD;
			end else if (dec_test) begin
				// only flags move; the accumulator is never written
				flag_n <= sum_register[`BTS_SIGN32];
				flag_z <= sum_register == {2*DW{1'b0}};
				flags_we <= 1'b1;
			end else if (dec_trap) begin
				// flush first so nothing after the trap completes
				pipe_flush <= 1'b1;
				// irq mask and enables are not consulted here
				irq_block <= 1'b1;
				vec_reg <= instr_word1[`BTS_VEC_HI:`BTS_VEC_LO];
				vector_kind <= vec_class(instr_word1[`BTS_VEC_HI:`BTS_VEC_LO]);
				ret_reg <= instr_pc + `BTS_RET_STEP;
				mem_rd <= 1'b1;
				mem_wide <= 1'b1;
				mem_addr <= `BTS_VEC_BASE + {{(AW-6){1'b0}}, instr_word1[`BTS_VEC_HI:`BTS_VEC_LO], 1'b0};
				busy <= 1'b1;
				state_reg <= ST_TRAP_GAP;
			end
		end
		ST_RMW_RD: begin
			// read data stands only from the next cycle; memory port assumed one-cycle
			state_reg <= ST_RMW_WR;
		end
		ST_RMW_WR: begin
			bit_probe_flag <= |(old_word & cur_mask);
			if (half_reg) begin
				// accumulator half target: flags from the result
				sum_half_we <= 1'b1;
				sum_half_sel <= half_hi_reg;
				sum_half_wdata <= new_word;
				flag_n <= new_word[`BTS_SIGN16];
				flag_z <= new_word == 16'h0000;
				flags_we <= 1'b1;
			end else begin
				mem_wr <= 1'b1;
				mem_wide <= 1'b0;
				mem_addr <= addr_reg;
				mem_wdata <= {{DW{1'b0}}, new_word};
			end
			busy <= 1'b0;
			state_reg <= ST_IDLE;
		end
		ST_TRAP_GAP: begin
			// vector word stands only from the next cycle; latching
			// here would take the previous bus value
			state_reg <= ST_TRAP_VEC;
		end
		ST_TRAP_VEC: begin
			vec_target_reg <= mem_rdata[AW-1:0];
			sp_reg <= stack_pointer + `BTS_STK_FIRST_STEP;
			save_idx_reg <= 3'h0;
			state_reg <= ST_TRAP_SAVE;
		end
		ST_TRAP_SAVE: begin
			// one 32-bit write per pair, low word at the even address
			mem_wr <= 1'b1;
			mem_wide <= 1'b1;
			// 32-bit accesses sit on an even address: the low pointer
			// bit is dropped so the low register lands even
			mem_addr <= {{(AW-DW){1'b0}}, sp_reg[DW-1:1], 1'b0};
			mem_wdata <= save_pair;
			sp_reg <= sp_reg + `BTS_STK_STEP;
			save_idx_reg <= save_idx_reg + 3'h1;
			if (save_idx_reg == `BTS_SAVE_LAST)
				state_reg <= ST_TRAP_END;
		end
		ST_TRAP_END: begin
			stack_pointer_new <= sp_reg;
			stack_pointer_we <= 1'b1;
			// masks up, permit/loop/sleep cleared; other bits kept
			// final pointer is one step past the last push
			status_word_b_new <= (status_word_b | (16'h0001 << `BTS_STB_IRQ_MASK)
				| (16'h0001 << `BTS_STB_DBG_MASK))
				& ~((16'h0001 << `BTS_STB_PERMIT) | (16'h0001 << `BTS_STB_LOOP)
				| (16'h0001 << `BTS_STB_SLEEP));
			status_word_b_we <= 1'b1;
			// vector 0 just jumps: no reset request is raised
			pc_load <= 1'b1;
			pc_value <= vec_target_reg;
			irq_block <= 1'b0;
			busy <= 1'b0;
			state_reg <= ST_IDLE;
		end
		default: begin
			busy <= 1'b0;
			irq_block <= 1'b0;
			state_reg <= ST_IDLE;
		end
		endcase
	end
end

endmodule // bts_exec

`default_nettype wire

// File: tb/bts_exec_properties.sv
/* port-level timing checks for bts_exec.
   assumes one core clock and a bind onto every bts_exec. */
`timescale 1ns/1ps
`default_nettype none
module bts_exec_properties (
	input wire core_clk,
	input wire sys_rst,
	input wire instr_valid,
	input wire [15:0] instr_word1,
	input wire [15:0] instr_word2,
	input wire [21:0] operand_addr,
	input wire [31:0] sum_register,
	input wire repeat_active,
	input wire busy,
	input wire flag_n,
	input wire flag_z,
	input wire flags_we,
	input wire repeat_counter_clr,
	input wire irq_block,
	input wire pipe_flush,
	input wire mem_rd,
	input wire mem_wr,
	input wire mem_wide,
	input wire [21:0] mem_addr,
	input wire [31:0] mem_wdata,
	input wire [15:0] status_word_b_new,
	input wire status_word_b_we,
	input wire stack_pointer_we,
	input wire sum_half_we,
	input wire pc_load
);
	// instruction taken at this edge
	wire take = !busy && instr_valid;
	wire bit_op = (instr_word1 == 16'h5609 || instr_word1 == 16'h560d) && instr_word2[15:12] == 4'h0;
	// memory target: accumulator half modes excluded
	wire mem_bit = take && bit_op && instr_word2[7:1] != 7'h54;
	wire trap = take && (instr_word1 & 16'hffe0) == 16'h0020;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_test; (take && instr_word1 == 16'hff58) |=> flags_we && flag_n == $past(sum_register[31])
		&& flag_z == ($past(sum_register) == 32'h0); endproperty
	a_test: assert property (p_test)
		else $error("accumulator test flags wrong");
	property p_rpt; (mem_bit && repeat_active) |=> repeat_counter_clr; endproperty
	a_rpt: assert property (p_rpt)
		else $error("repeat counter not cleared");
	property p_rd; mem_bit |=> mem_rd && !mem_wide && busy && mem_addr == $past(operand_addr); endproperty
	a_rd: assert property (p_rd)
		else $error("bit op read missing");
	property p_clr; (mem_bit && instr_word1 == 16'h5609) |=> ##2 mem_wr && mem_wdata[$past(instr_word2[11:8], 3)] == 1'b0; endproperty
	a_clr: assert property (p_clr)
		else $error("cleared bit not zero");
	property p_set; (mem_bit && instr_word1 == 16'h560d) |=> ##2 mem_wr && mem_wdata[$past(instr_word2[11:8], 3)] == 1'b1; endproperty
	a_set: assert property (p_set)
		else $error("set bit not one");
	property p_fetch; trap |=> pipe_flush && irq_block && mem_rd && mem_wide
		&& mem_addr == 22'h000d00 + {$past(instr_word1[4:0]), 1'b0}; endproperty
	a_fetch: assert property (p_fetch)
		else $error("trap vector fetch wrong");
	property p_end; trap |-> ##[10:11] (pc_load && status_word_b_we && stack_pointer_we); endproperty
	a_end: assert property (p_end)
		else $error("trap did not finish");
	property p_block; $rose(irq_block) |-> irq_block [*8]; endproperty
	a_block: assert property (p_block)
		else $error("interrupt hold released early");
	property p_stb; status_word_b_we |-> status_word_b_new[1:0] == 2'b11 && status_word_b_new[7:6] == 2'b00
		&& !status_word_b_new[4]; endproperty
	a_stb: assert property (p_stb)
		else $error("mode bits wrong after trap");
	property p_wide; (irq_block && mem_wr) |-> mem_wide; endproperty
	a_wide: assert property (p_wide)
		else $error("context write not wide");
	property p_align; (mem_wr && mem_wide) |-> !mem_addr[0]; endproperty
	a_align: assert property (p_align)
		else $error("wide write on odd address");
	property p_release; $fell(irq_block) |-> pc_load; endproperty
	a_release: assert property (p_release)
		else $error("interrupt hold dropped before jump");
	property p_half; (take && bit_op && instr_word2[7:1] == 7'h54) |=> ##2 (sum_half_we && flags_we && !mem_wr); endproperty
	a_half: assert property (p_half)
		else $error("accumulator half not written");
	c_half: cover property (sum_half_we);
	c_trap: cover property (trap);
	c_test: cover property (flags_we);
	c_bit: cover property (mem_wr && !mem_wide);
endmodule // bts_exec_properties
bind bts_exec bts_exec_properties u_bts_exec_properties (.core_clk, .sys_rst, .instr_valid, .instr_word1,
	.instr_word2, .operand_addr, .sum_register, .repeat_active, .busy, .flag_n, .flag_z, .flags_we,
	.repeat_counter_clr, .irq_block, .pipe_flush, .mem_rd, .mem_wr, .mem_wide, .mem_addr, .mem_wdata,
	.status_word_b_new, .status_word_b_we, .stack_pointer_we, .sum_half_we, .pc_load);
`default_nettype wire

// File: tb/bts_mem_model.sv
/* data memory with the vector table in it.
   assumes read data is used the cycle after the strobe. */
`timescale 1ns/1ps
`default_nettype none
module bts_mem_model (
	input wire logic core_clk,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic mem_wide,
	input wire logic [21:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata
);
	logic [15:0] mem [0:4095]; // upper address bits ignored
	wire [11:0] a = mem_addr[11:0];
	// vector v points at 0x100 + v
	initial begin
		mem_rdata = 32'h0;
		for (int v = 0; v < 32; v++) begin
			mem[12'hd00 + 2 * v] = 16'h0100 + v;
			mem[12'hd01 + 2 * v] = 16'h0000;
		end
	end
	////////////////////////////////////////////////////////////////
	// read answers once, then the bus is not held
	always @(posedge core_clk) begin
		if (mem_rd) begin
			mem_rdata <= {mem[a + 12'h1], mem[a]};
		end else begin
			mem_rdata <= ~mem_rdata;
		end
		if (mem_wr) begin
			mem[a] <= mem_wdata[15:0];
			if (mem_wide) begin
				mem[a + 12'h1] <= mem_wdata[31:16];
			end
		end
	end
endmodule // bts_mem_model
`default_nettype wire

// File: tb/bts_exec_tb.sv
/* scenario bench for bts_exec.
   assumes the memory model and checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module bts_exec_tb;
	logic core_clk = 0, sys_rst = 1, instr_valid = 0, repeat_active = 0;
	logic [15:0] instr_word1 = 0, instr_word2 = 0, status_word_a = 16'h0a0a, status_word_b = 16'h00d1;
	logic [15:0] mul_high = 16'h7777, page_pointer = 16'h0003, debug_status_reg = 16'h0005;
	logic [15:0] irq_enable_reg = 16'h0060, stack_pointer = 16'h0040;
	logic [21:0] instr_pc = 22'h000123, operand_addr = 0;
	logic [31:0] sum_register = 0, product = 32'h11112222, aux_pair = 32'h33334444;
	wire [31:0] mem_rdata, mem_wdata;
	wire busy, bit_probe_flag, flag_n, flag_z, flags_we, sum_half_we, sum_half_sel, repeat_counter_clr;
	wire irq_block, pipe_flush, mem_rd, mem_wr, mem_wide, stack_pointer_we, status_word_b_we, pc_load;
	wire [15:0] sum_half_wdata, stack_pointer_new, status_word_b_new;
	wire [21:0] mem_addr, pc_value;
	wire [3:0] vector_kind;
	int num_errors = 0, n_compared = 0;
	always #12.5 core_clk = ~core_clk;
	bts_exec u_bts_exec (.core_clk, .sys_rst, .instr_valid, .instr_word1, .instr_word2, .instr_pc,
		.repeat_active, .operand_addr, .sum_register, .status_word_a, .status_word_b, .mul_high, .product,
		.aux_pair, .page_pointer, .debug_status_reg, .irq_enable_reg, .stack_pointer, .mem_rdata, .busy,
		.bit_probe_flag, .flag_n, .flag_z, .flags_we, .sum_half_we, .sum_half_sel, .sum_half_wdata,
		.repeat_counter_clr, .irq_block, .pipe_flush, .mem_rd, .mem_wr, .mem_wide, .mem_addr, .mem_wdata,
		.stack_pointer_new, .stack_pointer_we, .status_word_b_new, .status_word_b_we, .pc_load, .pc_value,
		.vector_kind);
	bts_mem_model u_bts_mem_model (.core_clk, .mem_rd, .mem_wr, .mem_wide, .mem_addr, .mem_wdata, .mem_rdata);
	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one-cycle instruction offer, valid dropped before busy matters
	task issue(input logic [15:0] w1, input logic [15:0] w2);
		@(posedge core_clk);
		#2;
		instr_word1 = w1;
		instr_word2 = w2;
		instr_valid = 1;
		@(posedge core_clk);
		#2;
		instr_valid = 0;
	endtask
	// bounded wait for busy to fall, plus one edge for memory writes
	task wait_idle;
		for (int i = 0; i < 20; i++) begin
			@(posedge core_clk);
			#2;
			if (busy === 1'b0) break;
		end
		@(posedge core_clk);
		#2;
	endtask
	task t_sum_test(input logic [31:0] v);
		sum_register = v;
		issue(16'hff58, 16'h0000);
		chk(flags_we, 1);
		chk({flag_n, flag_z}, {v[31], v == 0});
	endtask
	task t_bit(input logic clr, input logic [3:0] idx, input logic [15:0] init, input logic repeat_prefix);
		logic [15:0] ew;
		ew = clr ? init & ~(16'h1 << idx) : init | (16'h1 << idx);
		operand_addr = 22'h10 + idx;
		u_bts_mem_model.mem[12'h010 + idx] = init;
		repeat_active = repeat_prefix;
		issue(clr ? 16'h5609 : 16'h560d, {4'h0, idx, 8'h01});
		chk(repeat_counter_clr, repeat_prefix);
		repeat_active = 0;
		wait_idle;
		chk(u_bts_mem_model.mem[12'h010 + idx], ew);
		chk(bit_probe_flag, init[idx]);
	endtask
	// accumulator half as target: flags follow the new half
	task t_half(input logic clr, input logic sel, input logic [3:0] idx);
		logic [15:0] h, ew;
		h = sel ? sum_register[31:16] : sum_register[15:0];
		ew = clr ? h & ~(16'h1 << idx) : h | (16'h1 << idx);
		issue(clr ? 16'h5609 : 16'h560d, {4'h0, idx, sel ? 8'ha8 : 8'ha9});
		wait_idle;
		chk({sum_half_sel, sum_half_wdata}, {sel, ew});
		chk({flag_n, flag_z, bit_probe_flag}, {ew[15], ew == 0, h[idx]});
	endtask
	task t_trap(input logic [4:0] vec, input logic [3:0] kind);
		logic [31:0] e [0:6];
		instr_pc = 22'h000120 + vec;
		sum_register = 32'h5555aaaa ^ vec;
		e[0] = {mul_high, status_word_a};
		e[1] = sum_register;
		e[2] = product;
		e[3] = aux_pair;
		e[4] = {page_pointer, status_word_b};
		e[5] = {debug_status_reg, irq_enable_reg};
		e[6] = {10'h000, instr_pc + 22'h1};
		issue({11'h001, vec}, 16'h0000);
		wait_idle;
		chk(pc_value, 22'h000100 + vec);
		chk(vector_kind, kind);
		chk(stack_pointer_new, 16'h004f);
		chk(status_word_b_new, 16'h0003);
		for (int k = 0; k < 7; k++) begin
			chk({u_bts_mem_model.mem[12'h041 + 2 * k], u_bts_mem_model.mem[12'h040 + 2 * k]}, e[k]);
		end
	endtask
	task give_verdict;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge core_clk);
		#2;
		sys_rst = 0;
		t_sum_test(32'h80000000);
		t_sum_test(32'h00000000);
		t_bit(1, 4'h0, 16'h0001, 1);
		t_bit(1, 4'hf, 16'h7fff, 0);
		t_bit(0, 4'hf, 16'h0000, 1);
		t_bit(0, 4'h3, 16'h0008, 0);
		sum_register = 32'h00050004;
		t_half(1, 0, 4'h2);
		t_half(0, 1, 4'hf);
		t_trap(5'd0, 4'h0);
		t_trap(5'd14, 4'h1);
		t_trap(5'd15, 4'h2);
		t_trap(5'd16, 4'h3);
		t_trap(5'd17, 4'h4);
		t_trap(5'd18, 4'h5);
		t_trap(5'd19, 4'h6);
		t_trap(5'd31, 4'h7);
		give_verdict;
	end
	// hang guard at 4000 cycles, far beyond the roughly 140 cycles needed
	initial begin
		#100000;
		num_errors++;
		give_verdict;
	end
endmodule // bts_exec_tb
`default_nettype wire
